// File: pkg/ipr_pkg.sv
// interrupt priority register constants, bus offsets and carried types
// assumes a 32-bit ahb-lite register bus and 4-bit priority fields
package ipr_pkg;

	localparam int unsigned NUM_REGS    = 9;
	localparam int unsigned FIELDS      = 4;
	localparam int unsigned LEVEL_W     = 4;
	localparam int unsigned REG_W       = 16;
	localparam int unsigned NUM_SRC     = NUM_REGS * FIELDS;
	localparam int unsigned IDX_W       = 6;
	localparam int unsigned ADDR_W      = 32;
	localparam int unsigned DATA_W      = 32;

	// register byte offsets, one aligned word each
	localparam logic [7:0] OFF_PRIO_A     = 8'h00;
	localparam logic [7:0] OFF_PRIO_D     = 8'h04;
	localparam logic [7:0] OFF_PRIO_E     = 8'h08;
	localparam logic [7:0] OFF_PRIO_F     = 8'h0c;
	localparam logic [7:0] OFF_PRIO_G     = 8'h10;
	localparam logic [7:0] OFF_PRIO_H     = 8'h14;
	localparam logic [7:0] OFF_PRIO_I     = 8'h18;
	localparam logic [7:0] OFF_PRIO_K     = 8'h1c;
	localparam logic [7:0] OFF_PRIO_SPARE = 8'h20;
	localparam logic [7:0] OFF_LAST       = OFF_PRIO_SPARE;

	localparam logic [REG_W-1:0]   PRIO_RESET = 16'h0000;
	localparam logic [LEVEL_W-1:0] LEVEL_MASKED = 4'h0;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic [2:0] HSIZE_BYTE    = 3'h0;
	localparam logic [2:0] HSIZE_HALF    = 3'h1;

	typedef struct packed {
		logic               valid;
		logic [IDX_W-1:0]   index;
		logic [LEVEL_W-1:0] level;
	} ipr_grant_type;

	typedef struct packed {
		logic             write;
		logic             mapped;
		logic [3:0]       reg_sel;
		logic [1:0]       lanes;
	} ipr_access_type;

endpackage : ipr_pkg

// File: design/ipr_priority_regs.sv
// priority level registers with ahb-lite slave and pending-request ranking
// assumes pending inputs come from logic on i_clk, single-word bus master
//
// Operation
// - nine 16-bit read/write priority registers
// - four 4-bit fields per register
// - field is unsigned level, 0 lowest
// - stored level ranks its pending source
// - all fields reset to level 0
// - level 0 source is masked, never accepted
// - equal levels: smaller vector number wins
`timescale 1ns/1ps
module ipr_priority_regs (
	// clock and reset
	input  wire logic                                      i_clk,
	input  wire logic                                      i_rst_n,
	// ahb-lite slave
	input  wire logic                                      i_hsel,
	input  wire logic [ipr_pkg::ADDR_W-1:0]                i_haddr,
	input  wire logic [1:0]                                i_htrans,
	input  wire logic                                      i_hwrite,
	input  wire logic [2:0]                                i_hsize,
	input  wire logic [ipr_pkg::DATA_W-1:0]                i_hwdata,
	input  wire logic                                      i_hready,
	output logic      [ipr_pkg::DATA_W-1:0]                o_hrdata,
	output logic                                           o_hreadyout,
	output logic                                           o_hresp,
	// interrupt sources, bit n is source n in vector order
	input  wire logic [ipr_pkg::NUM_SRC-1:0]               i_pending,
	// stored levels, source n in bits 4n+3..4n
	output logic      [ipr_pkg::NUM_SRC*ipr_pkg::LEVEL_W-1:0] o_levels,
	// highest ranked pending source
	output ipr_pkg::ipr_grant_type                         o_grant
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// decode a byte address into register select and byte lanes
	function automatic ipr_pkg::ipr_access_type decode(
		input logic [ipr_pkg::ADDR_W-1:0] addr,
		input logic [2:0]                 size,
		input logic                       wr
	);
		ipr_pkg::ipr_access_type a;
		a.write   = wr;
		a.mapped  = (addr[ipr_pkg::ADDR_W-1:8] == '0) && (addr[7:0] <= ipr_pkg::OFF_LAST);
		a.reg_sel = addr[5:2];
		if (size == ipr_pkg::HSIZE_BYTE) begin
			a.lanes = {addr[1:0] == 2'h1, addr[1:0] == 2'h0};
		end else if (size == ipr_pkg::HSIZE_HALF) begin
			a.lanes = {~addr[1], ~addr[1]};
		end else begin
			a.lanes = 2'h3;
		end
		return a;
	endfunction : decode

	// merge write data into a register through byte lanes
	function automatic logic [ipr_pkg::REG_W-1:0] merge(
		input logic [ipr_pkg::REG_W-1:0] old_v,
		input logic [ipr_pkg::REG_W-1:0] new_v,
		input logic [1:0]                lanes
	);
		logic [ipr_pkg::REG_W-1:0] r;
		r = old_v;
		if (lanes[0]) begin
			r[7:0] = new_v[7:0];
		end
		if (lanes[1]) begin
			r[15:8] = new_v[15:8];
		end
		return r;
	endfunction : merge

	// level of source n: field 0 of a register sits at bits 15..12
	function automatic logic [ipr_pkg::LEVEL_W-1:0] level_of(
		input logic [ipr_pkg::NUM_REGS*ipr_pkg::REG_W-1:0] regs,
		input int unsigned                                 n
	);
		int unsigned r;
		int unsigned f;
		r = n / ipr_pkg::FIELDS;
		f = n % ipr_pkg::FIELDS;
		return regs[r*ipr_pkg::REG_W + (ipr_pkg::FIELDS-1-f)*ipr_pkg::LEVEL_W +: ipr_pkg::LEVEL_W];
	endfunction : level_of

	////////////////////////////////////////////////////////////////////////
	// bus state

	logic [ipr_pkg::NUM_REGS*ipr_pkg::REG_W-1:0] regs_q;
	logic [ipr_pkg::NUM_REGS*ipr_pkg::REG_W-1:0] regs_d;
	ipr_pkg::ipr_access_type                     acc_q;
	ipr_pkg::ipr_access_type                     acc_d;
	logic                                        wr_pend_q;
	logic                                        wr_pend_d;
	logic [ipr_pkg::DATA_W-1:0]                  rdata_q;
	logic [ipr_pkg::DATA_W-1:0]                  rdata_d;

	always_comb begin
		ipr_pkg::ipr_access_type a;
		logic                    take;
		a         = decode(i_haddr, i_hsize, i_hwrite);
		take      = i_hsel && i_hready &&
			(i_htrans == ipr_pkg::HTRANS_NONSEQ || i_htrans == ipr_pkg::HTRANS_SEQ);
		regs_d    = regs_q;
		acc_d     = acc_q;
		wr_pend_d = wr_pend_q;
		rdata_d   = rdata_q;
		// data phase of a write: commit hwdata
		if (wr_pend_q && acc_q.mapped) begin
			regs_d[acc_q.reg_sel*ipr_pkg::REG_W +: ipr_pkg::REG_W] = merge(
				regs_q[acc_q.reg_sel*ipr_pkg::REG_W +: ipr_pkg::REG_W],
				i_hwdata[ipr_pkg::REG_W-1:0], acc_q.lanes);
		end
		if (i_hready) begin
			wr_pend_d = take && a.write;
			acc_d     = a;
			rdata_d   = '0;
			// read data sampled after any write committing this edge
			if (take && !a.write && a.mapped) begin
				rdata_d[ipr_pkg::REG_W-1:0] =
					regs_d[a.reg_sel*ipr_pkg::REG_W +: ipr_pkg::REG_W];
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			regs_q    <= {ipr_pkg::NUM_REGS{ipr_pkg::PRIO_RESET}};
			acc_q     <= '0;
			wr_pend_q <= 1'b0;
			rdata_q   <= '0;
		end else begin
			regs_q    <= regs_d;
			acc_q     <= acc_d;
			wr_pend_q <= wr_pend_d;
			rdata_q   <= rdata_d;
		end
	end

	assign o_hrdata    = rdata_q;
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// ranking of pending requests

	ipr_pkg::ipr_grant_type                            grant_q;
	ipr_pkg::ipr_grant_type                            grant_d;
	logic [ipr_pkg::NUM_SRC*ipr_pkg::LEVEL_W-1:0]      levels_q;
	logic [ipr_pkg::NUM_SRC*ipr_pkg::LEVEL_W-1:0]      levels_d;

	always_comb begin
		logic [ipr_pkg::LEVEL_W-1:0] lvl;
		lvl      = '0;
		grant_d  = '0;
		levels_d = '0;
		for (int unsigned n = 0; n < ipr_pkg::NUM_SRC; n++) begin
			lvl = level_of(regs_q, n);
			levels_d[n*ipr_pkg::LEVEL_W +: ipr_pkg::LEVEL_W] = lvl;
			// strict compare keeps the smaller index on a tie
			if (i_pending[n] && lvl != ipr_pkg::LEVEL_MASKED &&
				(!grant_d.valid || lvl > grant_d.level)) begin
				grant_d.valid = 1'b1;
				grant_d.index = n[ipr_pkg::IDX_W-1:0];
				grant_d.level = lvl;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			grant_q  <= '0;
			levels_q <= '0;
		end else begin
			grant_q  <= grant_d;
			levels_q <= levels_d;
		end
	end

	assign o_grant  = grant_q;
	assign o_levels = levels_q;

endmodule : ipr_priority_regs

// File: tb/ipr_priority_regs_sva.sv
// checker for register bus answer and grant ranking
// assumes binding onto ipr_priority_regs
`timescale 1ns/1ps
module ipr_priority_regs_sva (
	// watched ports
	input wire logic                   i_clk,
	input wire logic                   i_rst_n,
	input wire logic [35:0]            i_pending,
	input wire logic [143:0]           o_levels,
	input wire ipr_pkg::ipr_grant_type o_grant,
	input wire logic [31:0]            o_hrdata,
	input wire logic                   o_hreadyout,
	input wire logic                   o_hresp
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic [35:0] pend_q;
	logic        found;
	logic [5:0]  bi;
	logic [3:0]  bl;
	sequence s_release;
		$rose(i_rst_n);
	endsequence
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) pend_q <= '0;
		else pend_q <= i_pending;
	end
	// strict compare keeps level 0 out and the lowest index on ties
	always_comb begin
		found = 1'b0;
		bi = '0;
		bl = '0;
		for (int n = 0; n < 36; n++) begin
			if (pend_q[n] && o_levels[4*n+:4] > bl) begin
				found = 1'b1;
				bi = 6'(n);
				bl = o_levels[4*n+:4];
			end
		end
	end
	chk_bus_okay: assert property (o_hreadyout && !o_hresp)
		else $error("bus answer not zero-wait okay");
	chk_upper_zero: assert property (o_hrdata[31:16] == 16'h0)
		else $error("read data upper half not zero");
	chk_reset_low: assert property (s_release |-> o_levels == '0 && !o_grant.valid)
		else $error("levels not zero after reset");
	chk_grant_valid: assert property (o_grant.valid == found)
		else $error("grant valid wrong");
	chk_grant_level: assert property (o_grant.valid |-> o_grant.level == bl)
		else $error("grant level wrong");
	chk_grant_index: assert property (o_grant.valid |-> o_grant.index == bi)
		else $error("grant index wrong");
	chk_grant_src: assert property (o_grant.valid |-> pend_q[o_grant.index])
		else $error("grant for source not pending");
endmodule : ipr_priority_regs_sva
bind ipr_priority_regs ipr_priority_regs_sva chk_u (.i_clk, .i_rst_n, .i_pending,
	.o_levels, .o_grant, .o_hrdata, .o_hreadyout, .o_hresp);

// File: tb/ipr_priority_regs_tb.sv
// testbench: register access, reset values and grant ranking
// assumes the checker file is compiled alongside
`timescale 1ns/1ps
module ipr_priority_regs_tb;
	logic                   i_clk = 1'b0;
	logic                   i_rst_n = 1'b0;
	logic                   i_hsel = 1'b0;
	logic [31:0]            i_haddr = '0;
	logic [1:0]             i_htrans = '0;
	logic                   i_hwrite = 1'b0;
	logic [2:0]             i_hsize = 3'h2;
	logic [31:0]            i_hwdata = '0;
	logic [35:0]            i_pending = '0;
	wire logic              i_hready;
	wire logic [31:0]       o_hrdata;
	wire logic              o_hreadyout;
	wire logic              o_hresp;
	wire logic [143:0]      o_levels;
	ipr_pkg::ipr_grant_type o_grant;
	int                     n_mismatch = 0;
	int                     comparisons = 0;
	logic [31:0]            d;
	assign i_hready = o_hreadyout;
	always #50 i_clk = ~i_clk;
	ipr_priority_regs dut_u (.i_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
		.i_hsize, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_pending,
		.o_levels, .o_grant);
	task check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : check
	// waits for a rising edge with hready high, read data taken at that edge
	task wait_rdy(output logic [31:0] rd);
		do begin
			@(posedge i_clk);
		end while (i_hready !== 1'b1);
		rd = o_hrdata;
	endtask : wait_rdy
	task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge i_clk);
		i_hsel <= 1'b1;
		i_htrans <= 2'h2;
		i_haddr <= a;
		i_hwrite <= w;
		wait_rdy(d);
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= wd;
		wait_rdy(d);
	endtask : bus
	task t_reset;
		for (int i = 0; i < 10; i++) begin
			bus(1'b0, 32'(i * 4), '0);
			check(d, 32'h0);
		end
		$display("reset test done");
	endtask : t_reset
	task t_rw;
		for (int i = 0; i < 10; i++) begin
			bus(1'b1, 32'(i * 4), {16'hffff, 16'h1357 + 16'(i) * 16'h1111});
			bus(1'b0, 32'(i * 4), '0);
			check(d, i < 9 ? {16'h0, 16'h1357 + 16'(i) * 16'h1111} : 32'h0);
		end
		$display("read write test done");
	endtask : t_rw
	task pend(input logic [35:0] p, input logic [31:0] exp);
		@(posedge i_clk);
		i_pending <= p;
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		check({21'h0, o_grant}, exp);
	endtask : pend
	task t_rank;
		bus(1'b1, 32'h0, 32'h0000_0f3f);
		@(posedge i_clk);
		@(negedge i_clk);
		check({16'h0, o_levels[15:0]}, 32'h0000_f3f0);
		pend(36'hf, 32'h41f);
		pend(36'h1, 32'h0);
		pend(36'h4, 32'h423);
		pend(36'h9, 32'h43f);
		pend(36'h14, 32'h423);
		bus(1'b1, 32'h20, 32'h0);
		pend(36'h1_0000_0000, 32'h0);
		$display("ranking test done");
	endtask : t_rank
	task finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	initial begin
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_reset;
		t_rw;
		t_rank;
		finish_test;
	end
	initial begin
		repeat (3000) @(posedge i_clk);
		n_mismatch++;
		finish_test;
	end
endmodule : ipr_priority_regs_tb
